// ### include/dcep_pkg.sv
// package: register layout, field positions and reset values for device control export
package dcep_pkg;

    // register indices on the plain software port (word addresses)
    localparam logic [3:0] DCEP_ADDR_DEVCTL    = 4'h0;
    localparam logic [3:0] DCEP_ADDR_DEVCTL2   = 4'h1;
    localparam logic [3:0] DCEP_ADDR_STATUS    = 4'h2;
    localparam logic [3:0] DCEP_ADDR_REQCHK    = 4'h3;
    localparam int         DCEP_ADDR_W         = 4;
    localparam int         DCEP_DATA_W         = 16;

    // device control field positions
    localparam int DCEP_DC_CORR_BIT   = 0;
    localparam int DCEP_DC_NONFATAL   = 1;
    localparam int DCEP_DC_FATAL_BIT  = 2;
    localparam int DCEP_DC_RO_BIT     = 4;
    localparam int DCEP_DC_EXTTAG_BIT = 8;
    localparam int DCEP_DC_AUXPWR_BIT = 10;

    // device control 2 field positions
    localparam int DCEP_DC2_CTO_LSB   = 0;
    localparam int DCEP_DC2_CTO_W     = 4;
    localparam int DCEP_DC2_CTODIS    = 4;
    localparam int DCEP_DC2_ATOMREQ   = 6;
    localparam int DCEP_DC2_ATOMBLK   = 7;
    localparam int DCEP_DC2_IDOREQ    = 8;
    localparam int DCEP_DC2_IDOCPL    = 9;
    localparam int DCEP_DC2_LTR       = 10;
    localparam int DCEP_DC2_PFXBLK    = 15;

    // reset values: every enable clear, timeout range 0000b
    localparam logic [15:0] DCEP_DEVCTL_RST   = 16'h0000;
    localparam logic [15:0] DCEP_DEVCTL2_RST  = 16'h0000;
    localparam logic [3:0]  DCEP_CTO_DEFAULT  = 4'h0;

    // request check register bits (software presents an outgoing request)
    localparam int DCEP_RC_ATOMIC  = 0;
    localparam int DCEP_RC_PREFIX  = 1;

    // status register bits
    localparam int DCEP_ST_ATOMBLK = 0;
    localparam int DCEP_ST_PFXBLK  = 1;
    localparam int DCEP_ST_ERRCOR  = 2;
    localparam int DCEP_ST_ERRFAT  = 3;

    typedef enum logic {DCEP_ENDPOINT, DCEP_ROOT_PORT} dcep_role_t;

endpackage

// ### include/dcep_reg_if.sv
// interface: shared control fields between the bank and the export stage
`timescale 1ns/100ps
`default_nettype none
interface dcep_reg_if;
    import dcep_pkg::*;
    logic [DCEP_DATA_W-1:0] devctl;
    logic [DCEP_DATA_W-1:0] devctl2;

    modport bank (output devctl, output devctl2);
    modport sink (input devctl, input devctl2);
endinterface
`default_nettype wire

// ### src/dcep_export.sv
// export stage: registers each control field except non-fatal enable and aux power onto its user-side output
`timescale 1ns/100ps
`default_nettype none
module dcep_export
    import dcep_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    dcep_reg_if.sink         regs,
    output logic             atomic_egress_block_out,
    output logic             atomic_requester_en_out,
    output logic             completion_timeout_disable_out,
    output logic [3:0]       completion_timeout_range_out,
    output logic             id_order_completion_en_out,
    output logic             id_order_request_en_out,
    output logic             latency_tolerance_report_en_out,
    output logic             e2e_prefix_block_out,
    output logic             correctable_report_en_out,
    output logic             relaxed_ordering_en_out,
    output logic             extended_tag_en_out,
    output logic             fatal_report_en_out
);
    // one flop stage per field so every output is straight from a flip-flop
    logic [15:0] dc_ff;
    logic [15:0] dc2_ff;
    logic [15:0] nxt_dc;
    logic [15:0] nxt_dc2;

    always_comb
    begin
        nxt_dc  = regs.devctl;
        nxt_dc2 = regs.devctl2;
        if (rst_in)
        begin
            nxt_dc  = DCEP_DEVCTL_RST;
            nxt_dc2 = DCEP_DEVCTL2_RST;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        dc_ff  <= nxt_dc;
        dc2_ff <= nxt_dc2;
    end

    // field taps, one cycle behind the bank [RULE16]
    assign atomic_egress_block_out         = dc2_ff[DCEP_DC2_ATOMBLK];   // [RULE1]
    assign atomic_requester_en_out         = dc2_ff[DCEP_DC2_ATOMREQ];   // [RULE2]
    assign completion_timeout_disable_out  = dc2_ff[DCEP_DC2_CTODIS];    // [RULE3]
    assign completion_timeout_range_out    = dc2_ff[DCEP_DC2_CTO_LSB +: DCEP_DC2_CTO_W]; // [RULE4]
    assign id_order_completion_en_out      = dc2_ff[DCEP_DC2_IDOCPL];    // [RULE6]
    assign id_order_request_en_out         = dc2_ff[DCEP_DC2_IDOREQ];    // [RULE7]
    assign latency_tolerance_report_en_out = dc2_ff[DCEP_DC2_LTR];       // [RULE8]
    assign e2e_prefix_block_out            = dc2_ff[DCEP_DC2_PFXBLK];    // [RULE9]
    assign correctable_report_en_out       = dc_ff[DCEP_DC_CORR_BIT];    // [RULE11]
    assign relaxed_ordering_en_out         = dc_ff[DCEP_DC_RO_BIT];      // [RULE13]
    assign extended_tag_en_out             = dc_ff[DCEP_DC_EXTTAG_BIT];  // [RULE14]
    assign fatal_report_en_out             = dc_ff[DCEP_DC_FATAL_BIT];   // [RULE12]
endmodule
`default_nettype wire

// ### src/dcep_bank.sv
// top: device control register bank with user-side exports and error gating
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE1: atomic egress block set means outgoing AtomicOp requests are blocked; resets 0.
// RULE2: user may issue AtomicOps only with requester enable and bus master set.
// RULE3: timeout disable output tells user logic to stop completion timers.
// RULE4: user times out completions by the 4-bit range output encoding.
// RULE5: device never acts on the timeout range, only presents it.
// RULE6: user sets IDO in completions only while completion IDO enable set.
// RULE7: user sets IDO in requests only while request IDO enable set.
// RULE8: latency tolerance reporting enable is presented, reset value 0.
// RULE9: prefix block 0 lets prefixed TLPs go; 1 forbids them; resets 0.
// RULE10: a TLP withheld by prefix blocking raises a prefix blocked error.
// RULE11: correctable reporting enable gates correctable messages; root port sends none.
// RULE12: fatal reporting enable gates fatal messages; root port sends none.
// RULE13: relaxed ordering attribute allowed only while relaxed ordering enable set.
// RULE14: extended tag enable allows 8-bit tags, else 5-bit tags only.
// RULE15: device never checks tag width of requests or completions.
// RULE16: each output follows its register field, updated in its clock domain.
module dcep_bank
    import dcep_pkg::*;
(
    input  wire logic                           core_clk_in,
    input  wire logic                           rst_in,
    input  wire logic [dcep_pkg::DCEP_ADDR_W-1:0] addr_in,
    input  wire logic [dcep_pkg::DCEP_DATA_W-1:0] wdata_in,
    input  wire logic                           wr_in,
    input  wire logic                           rd_in,
    input  wire logic                           root_port_in,
    input  wire logic                           bus_master_en_in,
    input  wire logic                           corr_err_event_in,
    input  wire logic                           fatal_err_event_in,
    output logic [dcep_pkg::DCEP_DATA_W-1:0]    rdata_out,
    output logic                                err_cor_msg_out,
    output logic                                err_fatal_msg_out,
    output logic                                prefix_blocked_err_out,
    output logic                                atomic_egress_block_out,
    output logic                                atomic_requester_en_out,
    output logic                                completion_timeout_disable_out,
    output logic [3:0]                          completion_timeout_range_out,
    output logic                                id_order_completion_en_out,
    output logic                                id_order_request_en_out,
    output logic                                latency_tolerance_report_en_out,
    output logic                                e2e_prefix_block_out,
    output logic                                correctable_report_en_out,
    output logic                                relaxed_ordering_en_out,
    output logic                                extended_tag_en_out,
    output logic                                fatal_report_en_out
);
    import dcep_pkg::*;

    dcep_reg_if regs ();

    // control registers and sticky status
    logic [15:0] devctl_ff;
    logic [15:0] devctl2_ff;
    logic [3:0]  status_ff;
    logic [15:0] rdata_ff;
    logic        cor_ff;
    logic        fat_ff;
    logic        pfx_ff;
    logic [1:0]  root_sync_ff;
    logic [1:0]  bme_sync_ff;
    logic [1:0]  corr_sync_ff;
    logic [1:0]  fatal_sync_ff;
    logic [15:0] nxt_devctl;
    logic [15:0] nxt_devctl2;
    logic [3:0]  nxt_status;
    logic [15:0] nxt_rdata;
    logic        nxt_cor;
    logic        nxt_fat;
    logic        nxt_pfx;

    // strap and event pins come from outside: two flops before any use
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            root_sync_ff  <= 2'h0;
            bme_sync_ff   <= 2'h0;
            corr_sync_ff  <= 2'h0;
            fatal_sync_ff <= 2'h0;
        end
        else
        begin
            root_sync_ff  <= {root_sync_ff[0], root_port_in};
            bme_sync_ff   <= {bme_sync_ff[0], bus_master_en_in};
            corr_sync_ff  <= {corr_sync_ff[0], corr_err_event_in};
            fatal_sync_ff <= {fatal_sync_ff[0], fatal_err_event_in};
        end
    end

    function automatic logic hit(input logic [3:0] a, input logic [3:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // register writes, request checks, message gating and read mux
    always_comb
    begin
        logic atom_blocked;
        logic pfx_blocked;
        atom_blocked = 1'b0;
        pfx_blocked  = 1'b0;
        nxt_devctl   = devctl_ff;
        nxt_devctl2  = devctl2_ff;
        nxt_status   = status_ff;
        nxt_rdata    = 16'h0000;
        if (wr_in && hit(addr_in, DCEP_ADDR_DEVCTL))
        begin
            nxt_devctl = wdata_in;
            nxt_devctl[DCEP_DC_AUXPWR_BIT] = 1'b0; // aux power unused, reads zero
        end
        if (wr_in && hit(addr_in, DCEP_ADDR_DEVCTL2))
        begin
            nxt_devctl2 = wdata_in; // range stored as written, never interpreted [RULE5]
        end
        // outgoing request presented by software; tag width never checked [RULE15]
        if (wr_in && hit(addr_in, DCEP_ADDR_REQCHK))
        begin
            atom_blocked = wdata_in[DCEP_RC_ATOMIC] & devctl2_ff[DCEP_DC2_ATOMBLK];  // [RULE1]
            pfx_blocked  = wdata_in[DCEP_RC_PREFIX] & devctl2_ff[DCEP_DC2_PFXBLK];  // [RULE9]
        end
        // status: write-one-to-clear, a same-cycle set wins
        if (wr_in && hit(addr_in, DCEP_ADDR_STATUS))
        begin
            nxt_status = status_ff & ~wdata_in[3:0];
        end
        nxt_cor = corr_sync_ff[1] & devctl_ff[DCEP_DC_CORR_BIT] & ~root_sync_ff[1];   // [RULE11]
        nxt_fat = fatal_sync_ff[1] & devctl_ff[DCEP_DC_FATAL_BIT] & ~root_sync_ff[1]; // [RULE12]
        nxt_pfx = pfx_blocked;                                                        // [RULE10]
        if (atom_blocked)
        begin
            nxt_status[DCEP_ST_ATOMBLK] = 1'b1;
        end
        if (pfx_blocked)
        begin
            nxt_status[DCEP_ST_PFXBLK] = 1'b1; // [RULE10]
        end
        if (nxt_cor)
        begin
            nxt_status[DCEP_ST_ERRCOR] = 1'b1;
        end
        if (nxt_fat)
        begin
            nxt_status[DCEP_ST_ERRFAT] = 1'b1;
        end
        if (rd_in)
        begin
            case (addr_in)
                DCEP_ADDR_DEVCTL:  nxt_rdata = devctl_ff;
                DCEP_ADDR_DEVCTL2: nxt_rdata = devctl2_ff;
                DCEP_ADDR_STATUS:  nxt_rdata = {11'h000, bme_sync_ff[1], status_ff};
                default:           nxt_rdata = 16'h0000;
            endcase
        end
        if (rst_in)
        begin
            nxt_devctl  = DCEP_DEVCTL_RST;
            nxt_devctl2 = DCEP_DEVCTL2_RST; // [RULE8]
            nxt_status  = 4'h0;
            nxt_rdata   = 16'h0000;
            nxt_cor     = 1'b0;
            nxt_fat     = 1'b0;
            nxt_pfx     = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        devctl_ff  <= nxt_devctl;
        devctl2_ff <= nxt_devctl2;
        status_ff  <= nxt_status;
        rdata_ff   <= nxt_rdata;
        cor_ff     <= nxt_cor;
        fat_ff     <= nxt_fat;
        pfx_ff     <= nxt_pfx;
    end

    assign regs.devctl  = devctl_ff;
    assign regs.devctl2 = devctl2_ff;

    assign rdata_out              = rdata_ff;
    assign err_cor_msg_out        = cor_ff;
    assign err_fatal_msg_out      = fat_ff;
    assign prefix_blocked_err_out = pfx_ff;

    // exports trail the bank by one cycle [RULE16]
    dcep_export u_export (
        .core_clk_in                     (core_clk_in),
        .rst_in                          (rst_in),
        .regs                            (regs.sink),
        .atomic_egress_block_out         (atomic_egress_block_out),
        .atomic_requester_en_out         (atomic_requester_en_out),
        .completion_timeout_disable_out  (completion_timeout_disable_out),
        .completion_timeout_range_out    (completion_timeout_range_out),
        .id_order_completion_en_out      (id_order_completion_en_out),
        .id_order_request_en_out         (id_order_request_en_out),
        .latency_tolerance_report_en_out (latency_tolerance_report_en_out),
        .e2e_prefix_block_out            (e2e_prefix_block_out),
        .correctable_report_en_out       (correctable_report_en_out),
        .relaxed_ordering_en_out         (relaxed_ordering_en_out),
        .extended_tag_en_out             (extended_tag_en_out),
        .fatal_report_en_out             (fatal_report_en_out)
    );
endmodule
`default_nettype wire

// ### dv/dcep_props.sv
// checker: port timing relations of the device control bank
`timescale 1ns/100ps
`default_nettype none
module dcep_props
    import dcep_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic        root_port_in,
    input wire logic        corr_err_event_in,
    input wire logic [15:0] rdata_out,
    input wire logic        err_cor_msg_out,
    input wire logic        prefix_blocked_err_out,
    input wire logic        atomic_egress_block_out,
    input wire logic [3:0]  completion_timeout_range_out,
    input wire logic        e2e_prefix_block_out,
    input wire logic        correctable_report_en_out,
    input wire logic        extended_tag_en_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // write decodes; exports land two edges after the write
    wire logic w0 = wr_in && addr_in == DCEP_ADDR_DEVCTL;
    wire logic w2 = wr_in && addr_in == DCEP_ADDR_DEVCTL2;
    wire logic wq = wr_in && addr_in == DCEP_ADDR_REQCHK;

    chk_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data seen without a read");
    chk_cto_follow: assert property (w2 |-> ##2 completion_timeout_range_out == $past(wdata_in[3:0], 2))
        else $error("timeout range export wrong");
    chk_pfx_follow: assert property (w2 |-> ##2 e2e_prefix_block_out == $past(wdata_in[15], 2))
        else $error("prefix block export wrong");
    chk_atom_follow: assert property (w2 |-> ##2 atomic_egress_block_out == $past(wdata_in[7], 2))
        else $error("atomic block export wrong");
    chk_tag_follow: assert property (w0 |-> ##2 extended_tag_en_out == $past(wdata_in[8], 2))
        else $error("extended tag export wrong");
    chk_corr_follow: assert property (w0 |-> ##2 correctable_report_en_out == $past(wdata_in[0], 2))
        else $error("correctable enable export wrong");
    chk_pfx_err_src: assert property (prefix_blocked_err_out |-> $past(wq && wdata_in[1]))
        else $error("prefix error without a prefixed request");
    chk_pfx_err_make: assert property (wq && wdata_in[1] && e2e_prefix_block_out |=> prefix_blocked_err_out)
        else $error("blocked prefix request not flagged");
    // event and strap both pass two sync flops and the message flop: three edges back
    chk_cor_gate: assert property ($rose(err_cor_msg_out) |-> $past(corr_err_event_in, 3)
        && !$past(root_port_in, 3) && correctable_report_en_out)
        else $error("correctable message not gated");
endmodule
bind dcep_bank dcep_props dcep_props_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .root_port_in(root_port_in), .corr_err_event_in(corr_err_event_in), .rdata_out(rdata_out),
    .err_cor_msg_out(err_cor_msg_out), .prefix_blocked_err_out(prefix_blocked_err_out),
    .atomic_egress_block_out(atomic_egress_block_out), .extended_tag_en_out(extended_tag_en_out),
    .completion_timeout_range_out(completion_timeout_range_out),
    .e2e_prefix_block_out(e2e_prefix_block_out), .correctable_report_en_out(correctable_report_en_out));
`default_nettype wire

// ### dv/dcep_user_model.sv
// model: user application policy taken from the exported controls
`timescale 1ns/100ps
`default_nettype none
module dcep_user_model
(
    input  wire logic       bm_in,
    input  wire logic       are_in,
    input  wire logic       ctd_in,
    input  wire logic [3:0] cto_in,
    input  wire logic       idoc_in,
    input  wire logic       idor_in,
    input  wire logic       pfx_in,
    input  wire logic       ro_in,
    input  wire logic       xt_in,
    output logic            atomic_ok_out,
    output logic            prefix_ok_out,
    output logic [1:0]      ido_ok_out,
    output logic            ro_ok_out,
    output logic [7:0]      tag_mask_out,
    output logic            timer_on_out
);
    // what the user side may do; the device itself enforces none of it
    assign atomic_ok_out = are_in && bm_in;
    assign prefix_ok_out = !pfx_in;
    assign ido_ok_out    = {idoc_in, idor_in};
    assign ro_ok_out     = ro_in;
    assign tag_mask_out  = xt_in ? 8'hFF : 8'h1F;
    // timers run only for a listed range and while not disabled
    assign timer_on_out  = !ctd_in && (cto_in inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA, 4'hD});
endmodule
`default_nettype wire

// ### dv/tb.sv
// testbench: register port traffic and export checks for the bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dcep_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rp = 1'b0, bm = 1'b1;
    logic        ce = 1'b0, fe = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rdata, dcw;
    logic        cor, fat, perr, aeb, are, ctd, idoc, idor, ltr, pfx, cre, ro, xt, fre, a_ok, p_ok;
    logic [3:0]  cto;
    logic [1:0]  ido_ok;
    logic        ro_ok;
    logic        tmr_on;
    logic [7:0]  tmask;
    int          miscompares = 0;
    int          n_compared = 0;
    logic [15:0] pats [8] = '{16'h8000, 16'h0011, 16'h00C2, 16'h0305, 16'h0406, 16'h8089,
                              16'h074A, 16'h87DD};
    logic [15:0] dcp [4] = '{16'h0001, 16'h0114, 16'h0004, 16'h0515};
    wire logic [15:0] got_x = {1'b0, aeb, are, ctd, cto, idoc, idor, ltr, pfx, cre, ro, xt, fre};

    initial forever #2.5 clk = ~clk;
    dcep_bank dcep_bank_i (.core_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wd),
        .wr_in(wr), .rd_in(rd), .root_port_in(rp), .bus_master_en_in(bm), .corr_err_event_in(ce),
        .fatal_err_event_in(fe), .rdata_out(rdata), .err_cor_msg_out(cor), .err_fatal_msg_out(fat),
        .prefix_blocked_err_out(perr), .atomic_egress_block_out(aeb), .atomic_requester_en_out(are),
        .completion_timeout_disable_out(ctd), .completion_timeout_range_out(cto),
        .id_order_completion_en_out(idoc), .id_order_request_en_out(idor),
        .latency_tolerance_report_en_out(ltr), .e2e_prefix_block_out(pfx),
        .correctable_report_en_out(cre), .relaxed_ordering_en_out(ro),
        .extended_tag_en_out(xt), .fatal_report_en_out(fre));
    dcep_user_model dcep_user_model_i (.bm_in(bm), .are_in(are), .ctd_in(ctd), .cto_in(cto),
        .idoc_in(idoc), .idor_in(idor), .pfx_in(pfx), .ro_in(ro), .xt_in(xt),
        .atomic_ok_out(a_ok), .prefix_ok_out(p_ok), .ido_ok_out(ido_ok), .ro_ok_out(ro_ok),
        .tag_mask_out(tmask), .timer_on_out(tmr_on));

    // expected export vector, in the same order as got_x
    function automatic logic [15:0] expv(input logic [15:0] dc, input logic [15:0] d2);
        return {1'b0, d2[DCEP_DC2_ATOMBLK], d2[DCEP_DC2_ATOMREQ], d2[DCEP_DC2_CTODIS],
            d2[DCEP_DC2_CTO_LSB +: 4], d2[DCEP_DC2_IDOCPL], d2[DCEP_DC2_IDOREQ], d2[DCEP_DC2_LTR],
            d2[DCEP_DC2_PFXBLK], dc[DCEP_DC_CORR_BIT], dc[DCEP_DC_RO_BIT],
            dc[DCEP_DC_EXTTAG_BIT], dc[DCEP_DC_FATAL_BIT]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // one bus cycle; strobes last exactly one edge
    task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wd <= d;
        @(posedge clk);
    endtask
    task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
        cyc(1'b0, 1'b1, a, 16'h0000);
        #1;
        chk(nm, exp, rdata);
    endtask
    // write, then one idle edge so the exports have landed
    task automatic wrx(input logic [3:0] a, input logic [15:0] d);
        cyc(1'b1, 1'b0, a, d);
        cyc(1'b0, 1'b0, a, d);
        #1;
    endtask
    task automatic print_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #20000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("exports", 16'h0000, got_x);
        rdchk("devctl2", DCEP_ADDR_DEVCTL2, 16'h0000);
        // every listed timeout code, mixed with the other enables
        for (int i = 0; i < 8; i++)
        begin
            dcw = dcp[i % 4];
            wrx(DCEP_ADDR_DEVCTL2, pats[i]);
            wrx(DCEP_ADDR_DEVCTL, dcw);
            chk("exports", expv(dcw, pats[i]), got_x);
            chk("no action", 16'h0000, {13'h0000, perr, cor, fat});
            // every listed range keeps the user timers running unless disabled
            chk("user policy", {4'h0, pats[i][DCEP_DC2_IDOCPL], pats[i][DCEP_DC2_IDOREQ],
                dcw[DCEP_DC_RO_BIT], (dcw[DCEP_DC_EXTTAG_BIT] ? 8'hFF : 8'h1F),
                !pats[i][DCEP_DC2_CTODIS]}, {4'h0, ido_ok, ro_ok, tmask, tmr_on});
            rdchk("devctl2", DCEP_ADDR_DEVCTL2, pats[i]);
            rdchk("devctl", DCEP_ADDR_DEVCTL, dcw & 16'hFBFF);
        end
        // unmapped place, then write and read back to back
        cyc(1'b1, 1'b0, 4'hF, 16'hFFFF);
        rdchk("unmapped", 4'hF, 16'h0000);
        cyc(1'b1, 1'b0, DCEP_ADDR_DEVCTL2, 16'h8080);
        rdchk("devctl2", DCEP_ADDR_DEVCTL2, 16'h8080);
        cyc(1'b0, 1'b0, 4'h0, 16'h0000);
        #1;
        chk("prefix ok", 16'h0000, {15'h0000, p_ok});
        cyc(1'b1, 1'b0, DCEP_ADDR_REQCHK, 16'h0003);
        #1;
        chk("prefix err", 16'h0001, {15'h0000, perr});
        cyc(1'b0, 1'b0, 4'h0, 16'h0000);
        #1;
        chk("prefix err", 16'h0000, {15'h0000, perr});
        rdchk("status", DCEP_ADDR_STATUS, 16'h0013);
        wrx(DCEP_ADDR_STATUS, 16'h0003);
        rdchk("status", DCEP_ADDR_STATUS, 16'h0010);
        // unblocked requests raise nothing
        wrx(DCEP_ADDR_DEVCTL2, 16'h0040);
        chk("atomic ok", 16'h0001, {15'h0000, a_ok});
        // bus master off forbids atomics even with the requester enable set
        bm <= 1'b0;
        cyc(1'b0, 1'b0, 4'h0, 16'h0000);
        #1;
        chk("atomic ok", 16'h0000, {15'h0000, a_ok});
        bm <= 1'b1;
        wrx(DCEP_ADDR_REQCHK, 16'h0003);
        rdchk("status", DCEP_ADDR_STATUS, 16'h0010);
        // error messages: endpoint enabled, endpoint disabled, root port
        for (int j = 0; j < 3; j++)
        begin
            rp <= (j == 2);
            wrx(DCEP_ADDR_DEVCTL, (j == 1) ? 16'h0000 : 16'h0005);
            repeat (4) @(posedge clk);
            ce <= 1'b1;
            fe <= 1'b1;
            repeat (5) @(posedge clk);
            #1;
            chk("err msgs", (j == 0) ? 16'h0003 : 16'h0000, {14'h0000, cor, fat});
            ce <= 1'b0;
            fe <= 1'b0;
            repeat (5) @(posedge clk);
        end
        // only the enabled endpoint pass may have left message flags behind
        rdchk("status", DCEP_ADDR_STATUS, 16'h001C);
        // second reset in mid-run clears every field
        wrx(DCEP_ADDR_DEVCTL2, 16'h87DD);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("exports", 16'h0000, got_x);
        rdchk("devctl2", DCEP_ADDR_DEVCTL2, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
